// ===== sfsir_pkg.sv
package sfsir_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_PRESC = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_RAW = 8'h18;
  localparam logic [7:0] OFF_MIS = 8'h1c;
  localparam logic [7:0] OFF_CLR = 8'h20;

  // ==========================================================================
  // field positions
  localparam int STAT_TX_EMPTY = 0;
  localparam int STAT_TX_SPACE = 1;
  localparam int STAT_RX_DATA = 2;
  localparam int STAT_RX_FULL = 3;
  localparam int STAT_ACTIVE = 4;
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_UNDERRUN = 2;
  localparam int IRQ_NUM = 6;

  // ==========================================================================
  // reset values
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [4:0] FRAME_M1_RESET = 5'h07;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [2:0] TRIG_RESET = 3'h0;

  // ==========================================================================
  // fifo sizing and trigger codes
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
  localparam logic [2:0] TRIG_1 = 3'h0;
  localparam logic [2:0] TRIG_4 = 3'h1;
  localparam logic [2:0] TRIG_8 = 3'h2;
  localparam logic [4:0] LVL_1 = 5'h01;
  localparam logic [4:0] LVL_4 = 5'h04;
  localparam logic [4:0] LVL_8 = 5'h08;

  // receive timeout, counted in serial bit periods
  localparam logic [5:0] RX_TIMEOUT_BITS = 6'h20;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LEAD = 2'h1,
    ST_TRAIL = 2'h3,
    ST_GAP = 2'h2
  } sfsir_state_e;

  typedef struct packed {
    logic slave_mode;
    logic port_enable;
    logic [7:0] serial_rate_value;
    logic [2:0] pad;
    logic [4:0] frame_size_m1;
  } sfsir_ctrl_s;

  typedef struct packed {
    logic [2:0] tx_trigger_level_sel;
    logic [2:0] rx_trigger_level_sel;
  } sfsir_trig_s;

  typedef struct packed {
    logic tx_empty;
    logic underrun;
    logic tx_level;
    logic rx_level;
    logic timeout;
    logic overrun;
  } sfsir_irq_s;

endpackage

// ===== sfsir_top.sv
`timescale 1ns/1ps
// Overview of operation
// - data read pops rx, write pushes tx
// - short tx frames right aligned, upper ignored
// - rx element right aligned, upper bits zero
// - status bit0 tx fifo empty, reset one
// - status bit1 tx fifo has space
// - status bit2 rx fifo holds data
// - status bit3 rx fifo full
// - status bit4 busy shifting or tx pending
// - bit rate clk over div times (1+rate)
// - rx push while full flags overrun
// - unread rx data times out
// - six mask enables, one enables, reset zero
// - raw status shows sources regardless of mask
// - masked status is raw and mask
// - rx/tx level trigger at 1, 4, 8
// - write one clears overrun, timeout, underrun
module sfsir_top
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic sclk_in,
  input wire logic cs_b_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_b_out,
  output logic mosi_out,
  output logic miso_out,
  output logic miso_oe_out
);

  // ==========================================================================
  // helper functions
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic level_hit(input logic [2:0] sel, input logic [4:0] cnt);
    case (sel)
      sfsir_pkg::TRIG_1: level_hit = (cnt >= sfsir_pkg::LVL_1);
      sfsir_pkg::TRIG_4: level_hit = (cnt >= sfsir_pkg::LVL_4);
      sfsir_pkg::TRIG_8: level_hit = (cnt >= sfsir_pkg::LVL_8);
      default: level_hit = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // pin synchronisers: [0] sclk, [1] cs_b, [2] mosi, [3] miso
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] pin_prev_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_q <= 4'h2;
      sync2_q <= 4'h2;
      pin_prev_q <= 2'h2;
    end
    else
    begin
      sync1_q <= {miso_in, mosi_in, cs_b_in, sclk_in};
      sync2_q <= sync1_q;
      pin_prev_q <= sync2_q[1:0];
    end
  end

  wire sclk_rise = sync2_q[0] & ~pin_prev_q[0];
  wire sclk_fall = ~sync2_q[0] & pin_prev_q[0];
  wire cs_fall = ~sync2_q[1] & pin_prev_q[1];
  wire cs_high = sync2_q[1];

  // ==========================================================================
  // avalon slave: one wait cycle, read data captured while waiting
  logic wait_q;
  logic [31:0] rdata_q;
  sfsir_pkg::sfsir_ctrl_s ctrl_q;
  sfsir_pkg::sfsir_trig_s trig_q;
  logic [7:0] presc_q;
  logic [5:0] mask_q;
  sfsir_pkg::sfsir_irq_s raw;
  logic [31:0] rd_mux;

  wire req = avs_read_in | avs_write_in;
  wire wr_acc = avs_write_in & ~wait_q;
  wire rd_acc = avs_read_in & ~wait_q;
  wire [7:0] adr = avs_address_in;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (avs_read_in & wait_q)
        rdata_q <= rd_mux;
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  // ==========================================================================
  // software registers
  wire [31:0] ctrl_word = {14'h0000, ctrl_q};
  wire [31:0] trig_word = {26'h000_0000, trig_q};
  wire [31:0] ctrl_new = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
  wire [31:0] trig_new = be_merge(trig_word, avs_writedata_in, avs_byteenable_in);
  wire [31:0] presc_new = be_merge({24'h00_0000, presc_q}, avs_writedata_in,
                                   avs_byteenable_in);
  wire [31:0] mask_new = be_merge({26'h000_0000, mask_q}, avs_writedata_in,
                                  avs_byteenable_in);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_q <= '{slave_mode: 1'b0, port_enable: 1'b0,
                  serial_rate_value: sfsir_pkg::RATE_RESET, pad: 3'h0,
                  frame_size_m1: sfsir_pkg::FRAME_M1_RESET};
      trig_q <= '{tx_trigger_level_sel: sfsir_pkg::TRIG_RESET,
                  rx_trigger_level_sel: sfsir_pkg::TRIG_RESET};
      presc_q <= sfsir_pkg::PRESC_RESET;
      mask_q <= sfsir_pkg::MASK_RESET;
    end
    else if (wr_acc)
    begin
      if (hit(adr, sfsir_pkg::OFF_CTRL))
      begin
        ctrl_q <= ctrl_new[17:0];
        ctrl_q.pad <= 3'h0;
      end
      if (hit(adr, sfsir_pkg::OFF_TRIG))
        trig_q <= trig_new[5:0];
      if (hit(adr, sfsir_pkg::OFF_PRESC))
        presc_q <= presc_new[7:0];
      if (hit(adr, sfsir_pkg::OFF_MASK))
        mask_q <= mask_new[5:0];
    end
  end

  // ==========================================================================
  // fifos
  logic [31:0] tx_mem [sfsir_pkg::FIFO_DEPTH];
  logic [31:0] rx_mem [sfsir_pkg::FIFO_DEPTH];
  logic [sfsir_pkg::FIFO_AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [4:0] tx_cnt_q, rx_cnt_q;
  logic tx_pop;
  logic rx_push;
  logic [31:0] rx_word;

  wire tx_empty = (tx_cnt_q == 5'h00);
  wire tx_full = (tx_cnt_q == sfsir_pkg::FIFO_FULL_CNT);
  wire rx_empty = (rx_cnt_q == 5'h00);
  wire rx_full = (rx_cnt_q == sfsir_pkg::FIFO_FULL_CNT);
  wire tx_push = wr_acc & hit(adr, sfsir_pkg::OFF_DATA) & ~tx_full;
  wire rx_pop = rd_acc & hit(adr, sfsir_pkg::OFF_DATA) & ~rx_empty;
  wire rx_store = rx_push & ~rx_full;
  wire overrun_set = rx_push & rx_full;
  wire [31:0] tx_head = tx_mem[tx_rp_q];

  always_ff @(posedge clk_in)
  begin
    if (tx_push)
      tx_mem[tx_wp_q] <= avs_writedata_in;
    if (rx_store)
      rx_mem[rx_wp_q] <= rx_word;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      tx_cnt_q <= 5'h00;
      rx_cnt_q <= 5'h00;
    end
    else
    begin
      tx_wp_q <= tx_wp_q + {3'h0, tx_push};
      tx_rp_q <= tx_rp_q + {3'h0, tx_pop};
      rx_wp_q <= rx_wp_q + {3'h0, rx_store};
      rx_rp_q <= rx_rp_q + {3'h0, rx_pop};
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_store} - {4'h0, rx_pop};
    end
  end

  // ==========================================================================
  // bit-rate prescaler: one tick per half bit period
  logic [6:0] half_cnt_q;
  logic [7:0] rate_cnt_q;
  logic bit_phase_q;

  // odd or zero divisors are not supported; zero is clamped to keep ticking
  wire [6:0] div_half = (presc_q[7:1] == 7'h00) ? 7'h01 : presc_q[7:1];
  wire half_wrap = (half_cnt_q >= div_half - 7'h01);
  wire rate_wrap = (rate_cnt_q >= ctrl_q.serial_rate_value);
  wire tick = half_wrap & rate_wrap;
  wire bit_tick = tick & bit_phase_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      half_cnt_q <= 7'h00;
      rate_cnt_q <= 8'h00;
      bit_phase_q <= 1'b0;
    end
    else
    begin
      half_cnt_q <= half_wrap ? 7'h00 : half_cnt_q + 7'h01;
      if (half_wrap)
        rate_cnt_q <= rate_wrap ? 8'h00 : rate_cnt_q + 8'h01;
      if (tick)
        bit_phase_q <= ~bit_phase_q;
    end
  end

  // ==========================================================================
  // shifter, serial mode 0 (clock idles low, sample on rise)
  sfsir_pkg::sfsir_state_e st_q, st_d;
  logic [31:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic sclk_q, sclk_d, cs_b_q, cs_b_d, mosi_q, mosi_d, miso_q, miso_d, oe_q, oe_d;
  logic underrun_set;

  wire [4:0] fm1 = ctrl_q.frame_size_m1;
  wire [31:0] tx_aligned = tx_head << (5'h1f - fm1);
  wire [31:0] rx_shifted = {rx_sh_q[30:0], ctrl_q.slave_mode ? sync2_q[2] : sync2_q[3]};
  wire [31:0] rx_keep = ~(32'hffff_ffff << ({1'b0, fm1} + 6'h01));
  assign rx_word = rx_shifted & rx_keep;
  wire master_go = ctrl_q.port_enable & ~ctrl_q.slave_mode;
  wire slave_go = ctrl_q.port_enable & ctrl_q.slave_mode;

  always_comb
  begin
    st_d = st_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    bit_cnt_d = bit_cnt_q;
    sclk_d = sclk_q;
    cs_b_d = cs_b_q;
    mosi_d = mosi_q;
    miso_d = miso_q;
    oe_d = oe_q;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    underrun_set = 1'b0;
    if (master_go)
    begin
      case (st_q)
        sfsir_pkg::ST_IDLE:
          if (tick & ~tx_empty)
          begin
            tx_pop = 1'b1;
            tx_sh_d = tx_aligned;
            mosi_d = tx_aligned[31];
            bit_cnt_d = fm1;
            cs_b_d = 1'b0;
            st_d = sfsir_pkg::ST_LEAD;
          end
        sfsir_pkg::ST_LEAD:
          if (tick)
          begin
            sclk_d = 1'b1;
            rx_sh_d = rx_shifted;
            // store on the last sampling edge, not one shift later
            rx_push = (bit_cnt_q == 5'h00);
            st_d = sfsir_pkg::ST_TRAIL;
          end
        sfsir_pkg::ST_TRAIL:
          if (tick)
          begin
            sclk_d = 1'b0;
            if (bit_cnt_q == 5'h00)
            begin
              cs_b_d = 1'b1;
              st_d = sfsir_pkg::ST_GAP;
            end
            else
            begin
              tx_sh_d = {tx_sh_q[30:0], 1'b0};
              mosi_d = tx_sh_q[30];
              bit_cnt_d = bit_cnt_q - 5'h01;
              st_d = sfsir_pkg::ST_LEAD;
            end
          end
        sfsir_pkg::ST_GAP:
          if (tick)
            st_d = sfsir_pkg::ST_IDLE;
        default:
          st_d = sfsir_pkg::ST_IDLE;
      endcase
    end
    else if (slave_go)
    begin
      if (cs_high)
      begin
        st_d = sfsir_pkg::ST_IDLE;
        oe_d = 1'b0;
      end
      else
      begin
        case (st_q)
          sfsir_pkg::ST_IDLE, sfsir_pkg::ST_GAP:
            if (cs_fall | (st_q == sfsir_pkg::ST_GAP))
            begin
              // an empty fifo at frame start sends zeros and flags underrun
              tx_pop = ~tx_empty;
              underrun_set = tx_empty;
              tx_sh_d = tx_empty ? 32'h0000_0000 : tx_aligned;
              miso_d = tx_empty ? 1'b0 : tx_aligned[31];
              oe_d = 1'b1;
              bit_cnt_d = fm1;
              st_d = sfsir_pkg::ST_LEAD;
            end
          sfsir_pkg::ST_LEAD:
            if (sclk_rise)
            begin
              rx_sh_d = rx_shifted;
              rx_push = (bit_cnt_q == 5'h00);
              st_d = sfsir_pkg::ST_TRAIL;
            end
          sfsir_pkg::ST_TRAIL:
            if (sclk_fall)
            begin
              if (bit_cnt_q == 5'h00)
                st_d = sfsir_pkg::ST_GAP;
              else
              begin
                tx_sh_d = {tx_sh_q[30:0], 1'b0};
                miso_d = tx_sh_q[30];
                bit_cnt_d = bit_cnt_q - 5'h01;
                st_d = sfsir_pkg::ST_LEAD;
              end
            end
          default:
            st_d = sfsir_pkg::ST_IDLE;
        endcase
      end
    end
    else
    begin
      st_d = sfsir_pkg::ST_IDLE;
      sclk_d = 1'b0;
      cs_b_d = 1'b1;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_q <= sfsir_pkg::ST_IDLE;
      tx_sh_q <= 32'h0000_0000;
      rx_sh_q <= 32'h0000_0000;
      bit_cnt_q <= 5'h00;
      sclk_q <= 1'b0;
      cs_b_q <= 1'b1;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      bit_cnt_q <= bit_cnt_d;
      sclk_q <= sclk_d;
      cs_b_q <= cs_b_d;
      mosi_q <= mosi_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  assign sclk_out = sclk_q;
  assign cs_b_out = cs_b_q;
  assign mosi_out = mosi_q;
  assign miso_out = miso_q;
  assign miso_oe_out = oe_q;

  // ==========================================================================
  // receive timeout and sticky interrupt sources
  logic [5:0] to_cnt_q;
  logic overrun_q, timeout_q, underrun_q, irq_q;

  wire clr_wr = wr_acc & hit(adr, sfsir_pkg::OFF_CLR) & avs_byteenable_in[0];
  wire [2:0] clr = clr_wr ? avs_writedata_in[2:0] : 3'h0;
  wire to_restart = rx_empty | rx_pop | rx_push;
  // a one-cycle pulse, so a clear is not undone by a count that stays
  wire timeout_set = bit_tick & ~to_restart &
                     (to_cnt_q == sfsir_pkg::RX_TIMEOUT_BITS - 6'h01);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      to_cnt_q <= 6'h00;
      overrun_q <= 1'b0;
      timeout_q <= 1'b0;
      underrun_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (to_restart)
        to_cnt_q <= 6'h00;
      else if (bit_tick & (to_cnt_q != sfsir_pkg::RX_TIMEOUT_BITS))
        to_cnt_q <= to_cnt_q + 6'h01;
      // a new event in the clearing cycle wins over the clear
      overrun_q <= (overrun_q & ~clr[sfsir_pkg::IRQ_OVERRUN]) | overrun_set;
      timeout_q <= (timeout_q & ~clr[sfsir_pkg::IRQ_TIMEOUT]) | timeout_set;
      underrun_q <= (underrun_q & ~clr[sfsir_pkg::IRQ_UNDERRUN]) | underrun_set;
      irq_q <= |(raw & mask_q);
    end
  end

  assign irq_out = irq_q;

  assign raw = '{tx_empty: tx_empty, underrun: underrun_q,
                 tx_level: level_hit(trig_q.tx_trigger_level_sel, tx_cnt_q),
                 rx_level: level_hit(trig_q.rx_trigger_level_sel, rx_cnt_q),
                 timeout: timeout_q, overrun: overrun_q};

  // ==========================================================================
  // read multiplexer
  wire busy = (st_q != sfsir_pkg::ST_IDLE) | ~tx_empty;
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[sfsir_pkg::STAT_TX_EMPTY] = tx_empty;
    stat_word[sfsir_pkg::STAT_TX_SPACE] = ~tx_full;
    stat_word[sfsir_pkg::STAT_RX_DATA] = ~rx_empty;
    stat_word[sfsir_pkg::STAT_RX_FULL] = rx_full;
    stat_word[sfsir_pkg::STAT_ACTIVE] = busy;
  end

  wire [31:0] data_word = rx_empty ? 32'h0000_0000 : rx_mem[rx_rp_q];
  wire [31:0] mis_word = {26'h000_0000, raw & mask_q};

  assign rd_mux = hit(adr, sfsir_pkg::OFF_CTRL) ? ctrl_word :
                  hit(adr, sfsir_pkg::OFF_TRIG) ? trig_word :
                  hit(adr, sfsir_pkg::OFF_DATA) ? data_word :
                  hit(adr, sfsir_pkg::OFF_STAT) ? stat_word :
                  hit(adr, sfsir_pkg::OFF_PRESC) ? {24'h00_0000, presc_q} :
                  hit(adr, sfsir_pkg::OFF_MASK) ? {26'h000_0000, mask_q} :
                  hit(adr, sfsir_pkg::OFF_RAW) ? {26'h000_0000, raw} :
                  hit(adr, sfsir_pkg::OFF_MIS) ? mis_word :
                  32'h0000_0000;

endmodule

// ===== sfsir_top_asserts.sv
`timescale 1ns/1ps
module sfsir_top_asserts
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out
);
  // ==========================================================================
  // bus handshake
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_take;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_rd(logic [7:0] a);
    avs_read_in && avs_waitrequest_out && avs_address_in == a ##1 !avs_waitrequest_out;
  endsequence

  property p_answer;
    s_take |=> !avs_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_one_cycle;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("waitrequest low too long");
  property p_no_spurious;
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

  // ==========================================================================
  // status and interrupt reads
  property p_stat_space;
    s_rd(sfsir_pkg::OFF_STAT) |-> !avs_readdata_out[0] || avs_readdata_out[1];
  endproperty
  a_stat_space: assert property (p_stat_space) else $error("empty tx fifo shows no space");
  property p_stat_rx;
    s_rd(sfsir_pkg::OFF_STAT) |-> !avs_readdata_out[3] || avs_readdata_out[2];
  endproperty
  a_stat_rx: assert property (p_stat_rx) else $error("full rx fifo shows no data");
  property p_stat_busy;
    s_rd(sfsir_pkg::OFF_STAT) |-> avs_readdata_out[0] || avs_readdata_out[4];
  endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("pending tx data but not busy");
  property p_stat_rsvd;
    s_rd(sfsir_pkg::OFF_STAT) |-> avs_readdata_out[31:5] == 27'h0;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status upper bits set");
  property p_mask_rsvd;
    s_rd(sfsir_pkg::OFF_MASK) |-> avs_readdata_out[31:6] == 26'h0;
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask upper bits set");
  property p_mis_irq;
    s_rd(sfsir_pkg::OFF_MIS) ##0 (avs_readdata_out[5:0] != 6'h0) |-> ##[0:1] irq_out;
  endproperty
  a_mis_irq: assert property (p_mis_irq) else $error("masked source without irq");
endmodule

bind sfsir_top sfsir_top_asserts u_asserts
(
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .irq_out(irq_out)
);

// ===== sfsir_slave_model.sv
`timescale 1ns/1ps
// ============================================================================
// far-side slave: answers each bit with the complement of the master's bit
module sfsir_slave_model
(
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic sclk_in,
  input wire logic cs_b_in,
  input wire logic mosi_in,
  output logic miso_out
);
  logic idle_q;
  logic late_q;
  // deselected line is not held: a toggling pattern exposes stale sampling
  always @(posedge clk_in)
  begin
    idle_q <= ~idle_q;
    late_q <= ~mosi_in;
  end
  initial idle_q = 1'b0;
  assign miso_out = cs_b_in ? idle_q : (slow_in ? late_q : ~mosi_in);
endmodule

// ===== sfsir_tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_in;
  logic rst_b_in;
  logic [7:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  logic miso_line;
  logic sclk_out;
  logic cs_b_out;
  logic mosi_out;
  logic model_slow;
  logic cs_b_drv;
  logic miso_oe;
  logic sclk_prev;
  logic [31:0] rd;
  int failures;
  int check_count;
  int cycles;
  int sclk_cnt;
  int sclk_per;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
  logic lvl_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  sfsir_top DUT
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .irq_out(irq_out),
    .sclk_in(1'b0),
    .cs_b_in(cs_b_drv),
    .mosi_in(1'b0),
    .miso_in(miso_line),
    .sclk_out(sclk_out),
    .cs_b_out(cs_b_out),
    .mosi_out(mosi_out),
    .miso_out(),
    .miso_oe_out(miso_oe)
  );

  sfsir_slave_model u_slave
  (
    .clk_in(clk_in),
    .slow_in(model_slow),
    .sclk_in(sclk_out),
    .cs_b_in(cs_b_out),
    .mosi_in(mosi_out),
    .miso_out(miso_line)
  );

  // ==========================================================================
  // clock, bit period monitor, hang guard
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    sclk_prev <= sclk_out;
    if (sclk_out && !sclk_prev)
    begin
      sclk_per <= sclk_cnt;
      sclk_cnt <= 1;
    end
    else
      sclk_cnt <= sclk_cnt + 1;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100)
      failures++;
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, sfsir_pkg::OFF_STAT, 32'h0);
      n++;
    end
    while (rd[sfsir_pkg::STAT_ACTIVE] !== 1'b0 && n < 2000);
    if (n >= 2000)
      failures++;
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    rst_b_in = 1'b0;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    model_slow = 1'b0;
    cs_b_drv = 1'b1;
    sclk_prev = 1'b0;
    failures = 0;
    check_count = 0;
    cycles = 0;
    sclk_cnt = 0;
    sclk_per = 0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd_chk(sfsir_pkg::OFF_STAT, 32'h3, "status");
    rd_chk(sfsir_pkg::OFF_PRESC, 32'h0, "prescaler");
    rd_chk(sfsir_pkg::OFF_MASK, 32'h0, "mask");
    rd_chk(sfsir_pkg::OFF_MIS, 32'h0, "masked");
    check("irq", {31'h0, irq_out}, 32'h0);
    $display("test reset done");
    bus(1'b1, sfsir_pkg::OFF_MASK, 32'h3f);
    rd_chk(sfsir_pkg::OFF_MASK, 32'h3f, "mask");
    rd_chk(sfsir_pkg::OFF_RAW, 32'h20, "raw");
    bus(1'b1, sfsir_pkg::OFF_MASK, 32'h20);
    rd_chk(sfsir_pkg::OFF_MIS, 32'h20, "masked");
    check("irq", {31'h0, irq_out}, 32'h1);
    bus(1'b1, sfsir_pkg::OFF_MASK, 32'h0);
    rd_chk(sfsir_pkg::OFF_MIS, 32'h0, "masked");
    check("irq", {31'h0, irq_out}, 32'h0);
    bus(1'b1, sfsir_pkg::OFF_STAT, 32'h0);
    rd_chk(sfsir_pkg::OFF_STAT, 32'h3, "status");
    rd_chk(8'h40, 32'h0, "unmapped");
    rd_chk(sfsir_pkg::OFF_DATA, 32'h0, "empty pop");
    $display("test masks done");
    bus(1'b1, sfsir_pkg::OFF_PRESC, 32'h4);
    rd_chk(sfsir_pkg::OFF_PRESC, 32'h4, "prescaler");
    bus(1'b1, sfsir_pkg::OFF_CTRL, 32'h0001_0107);
    bus(1'b1, sfsir_pkg::OFF_DATA, 32'hffff_ffa5);
    bus(1'b0, sfsir_pkg::OFF_STAT, 32'h0);
    check("busy", {31'h0, rd[4]}, 32'h1);
    wait_idle();
    // divisor 4 times (1 + rate 1)
    check("bit period", 32'(sclk_per), 32'h8);
    rd_chk(sfsir_pkg::OFF_STAT, 32'h7, "status");
    rd_chk(sfsir_pkg::OFF_DATA, 32'h5a, "rx element");
    rd_chk(sfsir_pkg::OFF_STAT, 32'h3, "status");
    $display("test transfer done");
    for (int i = 0; i < 4; i++)
      bus(1'b1, sfsir_pkg::OFF_DATA, 32'h10 + i);
    wait_idle();
    for (int j = 0; j < 4; j++)
    begin
      bus(1'b1, sfsir_pkg::OFF_TRIG, {26'h0, 3'h0, codes[j]});
      bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
      check("rx level", {31'h0, rd[2]}, {31'h0, lvl_exp[j]});
    end
    $display("test levels done");
    model_slow <= 1'b1;
    // 4 held plus 13 more: one beyond depth 16
    for (int i = 0; i < 13; i++)
      bus(1'b1, sfsir_pkg::OFF_DATA, 32'h20 + i);
    wait_idle();
    rd_chk(sfsir_pkg::OFF_STAT, 32'hf, "rx full");
    // timeout is 32 bit periods of 8 cycles
    repeat (300) @(posedge clk_in);
    bus(1'b1, sfsir_pkg::OFF_MASK, 32'h3);
    bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
    check("overrun timeout", {30'h0, rd[1:0]}, 32'h3);
    rd_chk(sfsir_pkg::OFF_MIS, 32'h3, "masked");
    check("irq", {31'h0, irq_out}, 32'h1);
    bus(1'b1, sfsir_pkg::OFF_CLR, 32'h0);
    bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
    check("clear zero", {30'h0, rd[1:0]}, 32'h3);
    bus(1'b1, sfsir_pkg::OFF_CLR, 32'h3);
    bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
    check("clear one", {30'h0, rd[1:0]}, 32'h0);
    check("irq", {31'h0, irq_out}, 32'h0);
    rd_chk(sfsir_pkg::OFF_DATA, 32'hef, "oldest");
    rd_chk(sfsir_pkg::OFF_STAT, 32'h7, "status");
    $display("test overrun done");
    // slave mode, frame start with an empty tx fifo
    bus(1'b1, sfsir_pkg::OFF_CTRL, 32'h0003_0107);
    cs_b_drv <= 1'b0;
    repeat (8) @(posedge clk_in);
    check("slave oe", {31'h0, miso_oe}, 32'h1);
    bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
    check("underrun", {31'h0, rd[4]}, 32'h1);
    cs_b_drv <= 1'b1;
    bus(1'b1, sfsir_pkg::OFF_CLR, 32'h4);
    bus(1'b0, sfsir_pkg::OFF_RAW, 32'h0);
    check("underrun clear", {31'h0, rd[4]}, 32'h0);
    $display("test slave done");
    print_verdict();
  end
endmodule
